// >>> design/acquisition_prefill_control.sv
// acquisition prefill control with ahb-lite register slave
// Overview of operation
// - continuous mode: fill whole buffer before triggering
// - trigger evaluation starts after fill; offload only after the post-trigger fill
// - stop before first trigger: no offload
// - qualified mode: evaluate triggers from first sample
// - early trigger jumps straight to post-trigger fill
// - continuous mode ignores matches while filling
// - post position: 12% of depth after trigger
// - post share selectable 12%, 50% or 88%
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module acquisition_prefill_control #(
    parameter int unsigned WIDTH = prefill_pkg::WIDTH_DEF,
    parameter int unsigned DEPTH = prefill_pkg::DEPTH_DEF
) (
    input  wire logic             clk_sys_i,
    input  wire logic             reset_i,
    // sampled design logic
    input  wire logic [WIDTH-1:0] sample_i,
    input  wire logic             sample_valid_i,
    input  wire logic             trig_match_i,
    // ahb-lite slave
    input  wire logic             hsel_i,
    input  wire logic [31:0]      haddr_i,
    input  wire logic [1:0]       htrans_i,
    input  wire logic             hwrite_i,
    input  wire logic [2:0]       hsize_i,
    input  wire logic [31:0]      hwdata_i,
    input  wire logic             hready_i,
    output logic      [31:0]      hrdata_o,
    output logic                  hreadyout_o,
    output logic                  hresp_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = AW + 1;
    // post-trigger sample counts, rounded to nearest, at least one;
    // the trigger sample itself is the first post-trigger sample
    localparam int unsigned P12 =
        (DEPTH * prefill_pkg::POST_PCT_12 + 50) / 100;
    localparam int unsigned P50 =
        (DEPTH * prefill_pkg::POST_PCT_50 + 50) / 100;
    localparam int unsigned P88 =
        (DEPTH * prefill_pkg::POST_PCT_88 + 50) / 100;
    localparam logic [CW-1:0] POST_12 = CW'(P12 < 1 ? 1 : P12);
    localparam logic [CW-1:0] POST_50 = CW'(P50 < 1 ? 1 : P50);
    localparam logic [CW-1:0] POST_88 = CW'(P88 < 1 ? 1 : P88);
    localparam logic [CW-1:0] FULL    = CW'(DEPTH);

    prefill_pkg::acq_state_t  state;
    prefill_pkg::acq_conf_t   conf;
    prefill_pkg::acq_status_t stat;

    logic [AW-1:0]    wptr;
    logic [CW-1:0]    fill_cnt;
    logic [CW-1:0]    post_cnt;
    logic [CW-1:0]    post_len;
    logic [CW-1:0]    pre_quota;
    logic [AW-1:0]    trig_addr;
    logic [AW-1:0]    rd_idx;
    logic [CW-1:0]    rd_left;
    logic [WIDTH-1:0] rd_data;
    logic             we;
    logic             filled;
    logic             trig_take;
    logic             run_req;
    logic             stop_req;
    logic             pop_req;

    // ahb-lite address phase capture
    logic             dp_act;
    logic             dp_wr;
    logic [7:0]       dp_addr;
    logic             ap_take;

    assign ap_take     = hsel_i && hready_i && htrans_i[1];
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            dp_act  <= 1'b0;
            dp_wr   <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hready_i) begin
            dp_act  <= ap_take;
            dp_wr   <= hwrite_i;
            dp_addr <= haddr_i[7:0];
        end
    end

    assign run_req  = dp_act && dp_wr && dp_addr == prefill_pkg::OFS_CTRL
                      && hwdata_i[prefill_pkg::CTRL_RUN_BIT];
    assign stop_req = dp_act && dp_wr && dp_addr == prefill_pkg::OFS_CTRL
                      && hwdata_i[prefill_pkg::CTRL_STOP_BIT];
    assign pop_req  = dp_act && dp_wr && dp_addr == prefill_pkg::OFS_CTRL
                      && hwdata_i[prefill_pkg::CTRL_POP_BIT];

    // configuration is only taken while idle or done, so a run never sees it change
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            conf.qualify <= 1'b0;
            conf.pos     <= prefill_pkg::trig_pos_t'(prefill_pkg::POS_RESET);
        end else if (dp_act && dp_wr && dp_addr == prefill_pkg::OFS_CONF
                     && state != prefill_pkg::ST_PREFILL
                     && state != prefill_pkg::ST_ARMED
                     && state != prefill_pkg::ST_POST) begin
            conf.qualify <= hwdata_i[prefill_pkg::CONF_QUAL_BIT];
            conf.pos     <= prefill_pkg::trig_pos_t'(
                            hwdata_i[prefill_pkg::CONF_POS_LSB +: 2]);
        end
    end

    always_comb begin
        unique case (conf.pos)
            prefill_pkg::POS_MID: post_len = POST_50;
            prefill_pkg::POS_PRE: post_len = POST_88;
            default:              post_len = POST_12;
        endcase
    end
    assign pre_quota = FULL - post_len;
    assign filled    = fill_cnt == FULL;

    // continuous: matches during prefill are dropped; qualified: at once
    always_comb begin
        trig_take = 1'b0;
        if (state == prefill_pkg::ST_ARMED) begin
            trig_take = trig_match_i && sample_valid_i;
        end else if (state == prefill_pkg::ST_PREFILL && conf.qualify) begin
            trig_take = trig_match_i && sample_valid_i;
        end
    end

    assign we = sample_valid_i && (state == prefill_pkg::ST_PREFILL
                || state == prefill_pkg::ST_ARMED
                || state == prefill_pkg::ST_POST);

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state <= prefill_pkg::ST_IDLE;
        end else if (run_req) begin
            state <= prefill_pkg::ST_PREFILL;
        end else if (stop_req && state != prefill_pkg::ST_DONE) begin
            state <= prefill_pkg::ST_IDLE;
        end else begin
            unique case (state)
                prefill_pkg::ST_PREFILL: begin
                    if (trig_take) begin
                        state <= prefill_pkg::ST_POST;
                    end else if (!conf.qualify && fill_cnt == FULL - 1
                                 && sample_valid_i) begin
                        state <= prefill_pkg::ST_ARMED;
                    end else if (conf.qualify && sample_valid_i
                                 && fill_cnt == pre_quota - 1) begin
                        state <= prefill_pkg::ST_ARMED;
                    end
                end
                prefill_pkg::ST_ARMED: begin
                    if (trig_take) begin
                        state <= prefill_pkg::ST_POST;
                    end
                end
                prefill_pkg::ST_POST: begin
                    if (sample_valid_i && post_cnt == post_len - 1) begin
                        state <= prefill_pkg::ST_DONE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            wptr      <= '0;
            fill_cnt  <= '0;
            post_cnt  <= '0;
            trig_addr <= '0;
        end else if (run_req) begin
            wptr      <= '0;
            fill_cnt  <= '0;
            post_cnt  <= '0;
            trig_addr <= '0;
        end else if (we) begin
            wptr <= AW'(wptr + 1'b1);
            if (!filled) begin
                fill_cnt <= CW'(fill_cnt + 1'b1);
            end
            if (trig_take) begin
                trig_addr <= wptr;
            end
            if (state == prefill_pkg::ST_POST || trig_take) begin
                post_cnt <= CW'(post_cnt + 1'b1);
            end
        end
    end

    // offload: oldest sample first; short fills start at zero
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rd_idx  <= '0;
            rd_left <= '0;
        end else if (run_req) begin
            // a new run must not inherit the last offload window
            rd_idx  <= '0;
            rd_left <= '0;
        end else if (state == prefill_pkg::ST_POST && sample_valid_i
                     && post_cnt == post_len - 1) begin
            rd_idx  <= filled ? AW'(wptr + 1'b1) : '0;
            rd_left <= filled ? FULL : CW'(fill_cnt + 1'b1);
        end else if (pop_req && rd_left != '0) begin
            rd_idx  <= AW'(rd_idx + 1'b1);
            rd_left <= CW'(rd_left - 1'b1);
        end
    end

    sample_ram #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_ram (
        .clk_sys_i (clk_sys_i),
        .we_i      (we),
        .waddr_i   (wptr),
        .wdata_i   (sample_i),
        .raddr_i   (rd_idx),
        .rdata_o   (rd_data)
    );

    // offload allowed only for a completed, triggered acquisition
    always_comb begin
        stat.running    = state == prefill_pkg::ST_PREFILL
                          || state == prefill_pkg::ST_ARMED
                          || state == prefill_pkg::ST_POST;
        stat.filled     = filled;
        stat.triggered  = state == prefill_pkg::ST_POST
                          || state == prefill_pkg::ST_DONE;
        stat.done       = state == prefill_pkg::ST_DONE;
        stat.offload_ok = state == prefill_pkg::ST_DONE
                          && rd_left != '0;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (ap_take && !hwrite_i) begin
            unique case (haddr_i[7:0])
                prefill_pkg::OFS_CONF:
                    hrdata_o <= {26'h000_0000, conf.pos, 3'h0, conf.qualify};
                prefill_pkg::OFS_STATUS:
                    hrdata_o <= {27'h000_0000, stat};
                prefill_pkg::OFS_COUNT:
                    hrdata_o <= {8'h00, 8'(trig_addr), 8'(rd_left),
                                 8'(fill_cnt)};
                prefill_pkg::OFS_OFFLOAD:
                    hrdata_o <= stat.offload_ok ? 32'(rd_data) : 32'h0;
                default:
                    hrdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> design/sample_ram.sv
// sample store: one write port, one registered read port
`timescale 1ns/10ps
`default_nettype none
module sample_ram #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 64,
    parameter int unsigned AW    = $clog2(DEPTH)
) (
    input  wire logic             clk_sys_i,
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // no reset on the read register: contents are undefined until written
    always_ff @(posedge clk_sys_i) begin
        rdata_o <= mem[raddr_i];
    end
endmodule
`default_nettype wire

// >>> pkg/prefill_pkg.sv
// package: constants, register map and types for the acquisition prefill control
package prefill_pkg;
    localparam int unsigned  DEPTH_DEF      = 64;
    localparam int unsigned  WIDTH_DEF      = 8;
    // register byte offsets
    localparam logic [7:0]   OFS_CTRL       = 8'h00;
    localparam logic [7:0]   OFS_CONF       = 8'h04;
    localparam logic [7:0]   OFS_STATUS     = 8'h08;
    localparam logic [7:0]   OFS_COUNT      = 8'h0c;
    localparam logic [7:0]   OFS_OFFLOAD    = 8'h10;
    // control bits (write 1 = pulse)
    localparam int unsigned  CTRL_RUN_BIT   = 0;
    localparam int unsigned  CTRL_STOP_BIT  = 1;
    localparam int unsigned  CTRL_POP_BIT   = 2;
    // config fields
    localparam int unsigned  CONF_QUAL_BIT  = 0;
    localparam int unsigned  CONF_POS_LSB   = 4;
    localparam logic [1:0]   POS_RESET      = 2'h0;
    // post-trigger shares in percent, selected by position code
    localparam int unsigned  POST_PCT_12    = 12;
    localparam int unsigned  POST_PCT_50    = 50;
    localparam int unsigned  POST_PCT_88    = 88;

    typedef enum logic [1:0] {
        POS_POST = 2'h0,
        POS_MID  = 2'h1,
        POS_PRE  = 2'h2
    } trig_pos_t;

    typedef enum {
        ST_IDLE,
        ST_PREFILL,
        ST_ARMED,
        ST_POST,
        ST_DONE
    } acq_state_t;

    typedef struct packed {
        logic       qualify;
        trig_pos_t  pos;
    } acq_conf_t;

    typedef struct packed {
        logic       running;
        logic       filled;
        logic       triggered;
        logic       done;
        logic       offload_ok;
    } acq_status_t;
endpackage

// >>> testbench/acquisition_prefill_control_test.sv
// self-checking bench for the acquisition prefill control
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    failures++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module acquisition_prefill_control_test;
    logic        clk_sys_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [7:0]  sample_i = 8'h00;
    logic        sample_valid_i = 1'b0;
    logic        trig_match_i = 1'b0;
    logic        hsel;
    logic        hwrite;
    logic        hrdy;
    logic        hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic [7:0]  seq = 8'h00;
    int          failures = 0;
    int          samples_checked = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    acquisition_prefill_control u_dut (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .sample_i(sample_i),
        .sample_valid_i(sample_valid_i), .trig_match_i(trig_match_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
        .hresp_o(hresp)
    );
    debug_host_model u_host (
        .clk_sys_i(clk_sys_i), .hready_i(hrdy), .hrdata_i(hrdata),
        .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata)
    );
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a);
        u_host.xfer(1'b0, a, 32'h0, q);
    endtask
    // status order: running, filled, triggered, done, offload_ok
    task automatic st(input logic [4:0] e);
        rd(prefill_pkg::OFS_STATUS);
        `CHK(q[4:0], e)
    endtask
    task automatic feed(input int n, input logic m);
        repeat (n) begin
            @(posedge clk_sys_i);
            sample_valid_i <= 1'b1;
            trig_match_i <= m;
            sample_i <= seq;
            seq = seq + 8'h01;
        end
        @(posedge clk_sys_i);
        sample_valid_i <= 1'b0;
        trig_match_i <= 1'b0;
    endtask
    task automatic run(input logic [31:0] conf);
        wr(prefill_pkg::OFS_CONF, conf);
        wr(prefill_pkg::OFS_CTRL, 32'h1);
        seq = 8'h00;
    endtask
    task automatic report_and_stop;
        $display("compared %0d, mismatched %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rd(prefill_pkg::OFS_CONF);
        `CHK(q, 32'h0)
        st(5'b00000);
        wr(8'h20, 32'hffffffff);
        rd(8'h20);
        `CHK(q, 32'h0)
        $display("reset test over");
        run(32'h0);
        feed(63, 1'b1);
        st(5'b10000);
        feed(1, 1'b1);
        st(5'b11000);
        feed(3, 1'b0);
        feed(1, 1'b1);
        feed(6, 1'b0);
        st(5'b11100);
        feed(1, 1'b0);
        st(5'b01111);
        // late samples must not overwrite the frozen capture
        feed(4, 1'b1);
        rd(prefill_pkg::OFS_OFFLOAD);
        `CHK(q, 32'h0000000b)
        wr(prefill_pkg::OFS_CTRL, 32'h4);
        rd(prefill_pkg::OFS_OFFLOAD);
        `CHK(q, 32'h0000000c)
        rd(prefill_pkg::OFS_COUNT);
        `CHK(q, 32'h00033f40)
        $display("continuous test over");
        run(32'h0);
        feed(10, 1'b1);
        wr(prefill_pkg::OFS_CTRL, 32'h2);
        st(5'b00000);
        rd(prefill_pkg::OFS_OFFLOAD);
        `CHK(q, 32'h0)
        $display("stop test over");
        run(32'h11);
        feed(1, 1'b1);
        feed(30, 1'b0);
        st(5'b10100);
        feed(1, 1'b0);
        st(5'b00111);
        $display("qualified mid test over");
        // 88% share: 56 post samples, the trigger sample first
        run(32'h21);
        feed(1, 1'b1);
        feed(54, 1'b0);
        st(5'b10100);
        feed(1, 1'b0);
        st(5'b00111);
        rd(prefill_pkg::OFS_CONF);
        `CHK(q, 32'h00000021)
        $display("qualified pre test over");
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        report_and_stop;
    end
endmodule
`default_nettype wire

// >>> testbench/debug_host_model.sv
// host model: debug software reaching the registers over ahb-lite
`timescale 1ns/10ps
`default_nettype none
module debug_host_model (
    input  wire logic        clk_sys_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    output logic             hsel_o,
    output logic [31:0]      haddr_o,
    output logic [1:0]       htrans_o,
    output logic             hwrite_o,
    output logic [2:0]       hsize_o,
    output logic [31:0]      hwdata_o
);
    initial begin
        hsel_o = 1'b0;
        haddr_o = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end
    // no latency assumed; only the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys_i);
        hsel_o <= 1'b1;
        htrans_o <= 2'h2;
        hwrite_o <= w;
        haddr_o <= {24'h0, a};
        do @(posedge clk_sys_i); while (hready_i !== 1'b1);
        hsel_o <= 1'b0;
        htrans_o <= 2'h0;
        hwdata_o <= d;
        do @(posedge clk_sys_i); while (hready_i !== 1'b1);
        q = hrdata_i;
    endtask
endmodule
`default_nettype wire

// >>> testbench/prefill_sva.sv
// checker: bus and status relations of the prefill control
`timescale 1ns/10ps
`default_nettype none
module prefill_checker (
    input wire logic        clk_sys_i,
    input wire logic        reset_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o
);
    logic       rd_q;
    logic       wr_q;
    logic       qual_q;
    logic [7:0] a_q;
    wire        req = hsel_i & hready_i & htrans_i[1];
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // mode shadow is only right while conf is written when idle or done
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            qual_q <= 1'b0;
            a_q <= 8'h00;
        end else begin
            rd_q <= req & ~hwrite_i;
            wr_q <= req & hwrite_i;
            a_q <= haddr_i[7:0];
            if (wr_q && a_q == prefill_pkg::OFS_CONF)
                qual_q <= hwdata_i[prefill_pkg::CONF_QUAL_BIT];
        end
    end
    sequence s_stat;
        rd_q && a_q == prefill_pkg::OFS_STATUS;
    endsequence
    sequence s_gap;
        rd_q && a_q > prefill_pkg::OFS_OFFLOAD;
    endsequence
    ready_a: assert property (hreadyout_o)
        else $error("wait state inserted");
    okay_a: assert property (!hresp_o)
        else $error("error response");
    hold_a: assert property (!(req && !hwrite_i) |=> $stable(hrdata_o))
        else $error("read data moved without a read");
    gap_a: assert property (s_gap |-> hrdata_o == 32'h0)
        else $error("unmapped read not zero");
    done_trig_a: assert property (s_stat |-> !hrdata_o[1] || hrdata_o[2])
        else $error("done without trigger");
    run_done_a: assert property (s_stat |-> !(hrdata_o[4] && hrdata_o[1]))
        else $error("running while done");
    fill_trig_a: assert property (s_stat ##0 !qual_q |-> !hrdata_o[2] || hrdata_o[3])
        else $error("trigger before fill");
    offload_a: assert property (s_stat |-> !hrdata_o[0] || hrdata_o[1])
        else $error("offload before done");
endmodule
bind acquisition_prefill_control prefill_checker u_chk (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o)
);
`default_nettype wire
